// ===== pkg/fsoc_pkg.sv
// Constants for the fan speed output control block.
// Assumes a 25 MHz system clock; all counts derive from it.
package fsoc_pkg;
    // System clock rate in Hz
    localparam int unsigned CLK_HZ            = 25000000;
    // Start-up kick duration, in milliseconds
    localparam int unsigned STARTUP_KICK_MS   = 1000;
    // Kick duration in clock cycles
    localparam int unsigned STARTUP_KICK_CYC  = (CLK_HZ / 1000) * STARTUP_KICK_MS;
    // Width of the speed level field
    localparam int unsigned SPEED_W           = 3;
    // Speed level value after reset
    localparam logic [2:0]  SPEED_RST         = 3'h0;
    // Full speed level applied during the kick
    localparam logic [2:0]  SPEED_FULL        = 3'h7;
    // Index of the shutdown output within the upper pins
    localparam int unsigned SHUTDOWN_BIT      = 3;
    // Fan controller states
    typedef enum logic [2:0] {
        FSOC_IDLE = 3'h1,
        FSOC_KICK = 3'h2,
        FSOC_RUN  = 3'h4
    } fsoc_state_e;
endpackage

// ===== verilog/fsoc_kick_timer.sv
// Down counter timing the start-up kick.
// Assumes a synchronous load pulse and a shared clock enable.
`timescale 1ns/10ps
`default_nettype none
module fsoc_kick_timer #(
    parameter int unsigned COUNT = 25000000
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic load_i,
    output logic      done_o
);
    localparam int unsigned W = $clog2(COUNT + 1);
    logic [W-1:0] cnt_q;   // Remaining cycles

    // Refuse a count the down counter cannot serve
    if (COUNT < 1) begin : g_bad_count
        $error("COUNT must be at least one");
    end

    // Load on request, count down to zero otherwise
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
        end else if (ce_i) begin
            if (load_i) begin
                cnt_q <= W'(COUNT);
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - W'(1);
            end
        end
    end

    // Done while the count is exhausted
    assign done_o = (cnt_q == '0);
endmodule
`default_nettype wire

// ===== verilog/fsoc_top.sv
// Fan-mode drive of the upper four open-drain port pins.
// Assumes configuration inputs synchronous to clk_sys_i.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - After reset all pins released, floating
// - Fan mode only when enable bit set
// - Fan mode drives upper pins open-drain
// - Zero level asserts active-low shutdown
// - Nonzero level after zero or fan off: full-speed kick, then level
// - Each set level bit grounds its output
// - Fan mode blocks upper status bit setting
// - Reset clears level and enable
module fsoc_top #(
    parameter int unsigned KICK_CYCLES = fsoc_pkg::STARTUP_KICK_CYC
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    input  wire logic       cfg_we_i,       // Write strobe for level and enable
    input  wire logic [2:0] cfg_speed_i,    // New speed level
    input  wire logic       cfg_fan_en_i,   // New fan mode enable bit
    input  wire logic [3:0] gpio_oe_i,      // General purpose enables, upper pins
    input  wire logic [3:0] gpio_out_i,     // General purpose data, upper pins
    input  wire logic [3:0] gpio_stat_set_i,// Upper pin change events
    output logic      [3:0] pin_o,          // Upper pin output levels
    output logic      [3:0] pin_oe_o,       // Upper pin drive enables
    output logic      [3:0] stat_set_o,     // Gated status set events
    output logic            fan_mode_o,     // Fan mode active
    output logic      [2:0] speed_o         // Stored speed level
);
    logic             rs1_q, rst_n_q;       // Reset release synchroniser
    logic       [2:0] speed_q;              // Fan speed level
    logic             en_q;                 // Fan mode enable
    logic             load_q;               // Kick timer load pulse
    logic             done;                 // Kick interval over
    fsoc_pkg::fsoc_state_e st_q;            // Controller state
    logic       [3:0] pull_d;               // Pins to ground

    // Refuse a kick length the timer cannot count
    if (KICK_CYCLES < 1) begin : g_bad_kick
        $error("KICK_CYCLES must be at least one");
    end

    // Reset release through two flip-flops
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rs1_q   <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            // Release ripples through both stages
            rs1_q   <= 1'b1;
            rst_n_q <= rs1_q;
        end
    end

    // Level and enable storage
    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            // Level zero and fan mode off
            speed_q <= fsoc_pkg::SPEED_RST;
            en_q    <= 1'b0;
        end else if (ce_i && cfg_we_i) begin
            // One strobe writes level and enable together
            speed_q <= cfg_speed_i;
            en_q    <= cfg_fan_en_i;
        end
    end

    fsoc_kick_timer #(.COUNT(KICK_CYCLES)) u_kick (
        .clk_i   (clk_sys_i),
        .rst_n_i (rst_n_q),
        .ce_i    (ce_i),
        .load_i  (load_q),
        .done_o  (done)
    );

    // Controller state machine: idle, full-speed kick, then the level
    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            // Start idle with no timer load pending
            st_q   <= fsoc_pkg::FSOC_IDLE;
            load_q <= 1'b0;
        end else if (ce_i) begin
            // Load request lasts a single cycle
            load_q <= 1'b0;
            case (st_q)
                fsoc_pkg::FSOC_IDLE: begin
                    // Enabled with nonzero level
                    if (en_q && speed_q != 3'h0) begin
                        st_q   <= fsoc_pkg::FSOC_KICK;
                        load_q <= 1'b1;
                    end
                end
                fsoc_pkg::FSOC_KICK: begin
                    // Fan off or level cleared: drop the kick
                    if (!en_q || speed_q == 3'h0) begin
                        st_q <= fsoc_pkg::FSOC_IDLE;
                    // Timer ran out after its load took effect
                    end else if (done && !load_q) begin
                        st_q <= fsoc_pkg::FSOC_RUN;
                    end
                end
                fsoc_pkg::FSOC_RUN: begin
                    // Fan off or level cleared: back to idle
                    if (!en_q || speed_q == 3'h0) begin
                        st_q <= fsoc_pkg::FSOC_IDLE;
                    end
                end
                // Illegal code: recover to idle
                default: st_q <= fsoc_pkg::FSOC_IDLE;
            endcase
        end
    end

    // Which upper pins are grounded in fan mode
    always_comb begin
        pull_d = 4'h0;
        if (speed_q == 3'h0) begin
            // Level zero: only the shutdown line is grounded
            pull_d[fsoc_pkg::SHUTDOWN_BIT] = 1'b1;
        end else if (st_q == fsoc_pkg::FSOC_RUN) begin
            // Running: each set level bit grounds its resistor
            pull_d[2:0] = speed_q;
        end else begin
            // Starting: every feedback resistor grounded
            pull_d[2:0] = fsoc_pkg::SPEED_FULL;
        end
    end

    // Registered pin drive
    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_o    <= 4'h0;
            pin_oe_o <= 4'h0;
        end else if (ce_i) begin
            if (en_q) begin
                // Fan mode: open drain, grounded or released only
                pin_o    <= 4'h0;
                pin_oe_o <= pull_d;
            end else begin
                // General purpose settings pass unchanged
                pin_o    <= gpio_out_i;
                pin_oe_o <= gpio_oe_i;
            end
        end
    end

    // Status gating and visible state
    always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            stat_set_o <= 4'h0;
            fan_mode_o <= 1'b0;
            speed_o    <= 3'h0;
        end else if (ce_i) begin
            // Fan mode owns the pins, so their events are dropped
            stat_set_o <= en_q ? 4'h0 : gpio_stat_set_i;
            fan_mode_o <= en_q;
            speed_o    <= speed_q;
        end
    end

    // Shutdown pulled low whenever fan mode holds level zero
    shutdown_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
        ce_i && en_q && speed_q == 3'h0 |=> pin_oe_o[3] && !pin_o[3])
        else $error("shutdown not asserted at level zero");
    // Kick grounds all three feedback outputs
    kick_full_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
        ce_i && en_q && st_q == fsoc_pkg::FSOC_KICK && speed_q != 3'h0
        |=> pin_oe_o == 4'h7)
        else $error("kick not at full speed");
    // Run state follows the programmed level
    run_level_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
        ce_i && en_q && st_q == fsoc_pkg::FSOC_RUN && speed_q != 3'h0
        |=> pin_oe_o == {1'b0, $past(speed_q)})
        else $error("feedback outputs do not match level");
    // Entering kick loads the timer
    kick_load_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
        ce_i && st_q == fsoc_pkg::FSOC_IDLE && en_q && speed_q != 3'h0
        |=> load_q && st_q == fsoc_pkg::FSOC_KICK)
        else $error("kick timer not restarted");
    // Fan mode masks upper status events
    stat_mask_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
        ce_i && en_q |=> stat_set_o == 4'h0)
        else $error("status set during fan mode");
    // General purpose drive passes when fan mode off
    gp_pass_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
        ce_i && !en_q |=> pin_oe_o == $past(gpio_oe_i))
        else $error("general purpose drive not passed");
    // Fan mode never drives a pin high
    od_only_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
        fan_mode_o && $past(en_q) |-> pin_o == 4'h0)
        else $error("fan mode drove a pin high");
    // Released pins after reset
    rst_float_a: assert property (@(posedge clk_sys_i)
        !rst_n_q |-> pin_oe_o == 4'h0 && speed_q == 3'h0 && !en_q)
        else $error("pins or state not cleared in reset");
    // Exhausted timer ends the kick
    kick_exit_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
        ce_i && en_q && st_q == fsoc_pkg::FSOC_KICK && speed_q != 3'h0
        && done && !load_q |=> st_q == fsoc_pkg::FSOC_RUN)
        else $error("kick did not end on timer expiry");
    // Fan off or level zero always returns to idle
    idle_return_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
        ce_i && (!en_q || speed_q == 3'h0) |=> st_q == fsoc_pkg::FSOC_IDLE)
        else $error("controller did not return to idle");
    // Fan mode output mirrors the enable bit
    mode_mirror_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
        ce_i |=> fan_mode_o == $past(en_q))
        else $error("fan mode output does not follow enable");
    // Visible level follows the stored level
    speed_echo_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
        ce_i |=> speed_o == $past(speed_q))
        else $error("visible level does not follow stored level");
    // Low clock enable freezes pins and controller
    freeze_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
        !ce_i |=> $stable(pin_oe_o) && $stable(pin_o) && $stable(st_q))
        else $error("state changed while clock enable low");
endmodule
`default_nettype wire

// ===== bench/fsoc_fan_model.sv
// Regulator feedback network and fan seen through the four upper pins.
// Assumes a pull-up on every upper pin, so a released pin reads high.
`timescale 1ns/10ps
`default_nettype none
module fsoc_fan_model (
    input  wire logic [3:0] pin_i,     // Pin output levels
    input  wire logic [3:0] pin_oe_i,  // Pin drive enables
    output logic      [3:0] wire_o,    // Resolved pin levels
    output logic      [2:0] fb_gnd_o,  // Feedback resistors put to ground
    output logic            running_o  // Regulator enabled, fan turning
);
    // Open-drain resolution: a released pin is pulled high
    assign wire_o    = (pin_oe_i & pin_i) | ~pin_oe_i;
    // A low feedback pin puts its resistor in parallel
    assign fb_gnd_o  = ~wire_o[2:0];
    // Low shutdown line stops the regulator
    assign running_o = wire_o[3];
endmodule
`default_nettype wire

// ===== bench/fsoc_top_tb_top.sv
// Self-checking bench for the fan drive of the upper pins.
// Assumes the fan model is compiled first; kick shortened to 20 cycles.
`timescale 1ns/10ps
`default_nettype none
module fsoc_top_tb_top;
    localparam int unsigned KICK = 20;  // Short kick for simulation
    logic       clk_sys_i = 1'b0;       // 25 MHz system clock
    logic       rst_n_i   = 1'b0;       // Active-low reset
    logic       we = 1'b0, en = 1'b0;   // Write strobe and enable bit
    logic [2:0] spd = 3'h0;             // Level to write
    logic [3:0] g_oe = 4'h0, g_out = 4'h0, g_ev = 4'h0;
    logic [3:0] pin, oe, stat, lvl;     // Design outputs, resolved pins
    logic [2:0] spd_q, fb;              // Stored level, grounded resistors
    logic       fm, run;                // Fan mode, fan running
    logic       ce = 1'b1;              // Clock enable to the design
    int         num_errors = 0;
    int         total_checks = 0;
    // Clock generator
    always #20 clk_sys_i = ~clk_sys_i;
    fsoc_top #(.KICK_CYCLES(KICK)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .ce_i(ce), .cfg_we_i(we), .cfg_speed_i(spd), .cfg_fan_en_i(en),
        .gpio_oe_i(g_oe), .gpio_out_i(g_out), .gpio_stat_set_i(g_ev), .pin_o(pin),
        .pin_oe_o(oe), .stat_set_o(stat), .fan_mode_o(fm), .speed_o(spd_q));
    fsoc_fan_model fan (.pin_i(pin), .pin_oe_i(oe), .wire_o(lvl), .fb_gnd_o(fb),
        .running_o(run));
    // Compare one value and count it
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Wait n cycles, then step off the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    // One-cycle configuration write
    task automatic wr(input logic e, input logic [2:0] s);
        cyc(1);
        we  = 1'b1;
        en  = e;
        spd = s;
        cyc(1);
        we  = 1'b0;
    endtask
    // Reset pulse, then idle outputs and released pins
    task automatic t_reset();
        rst_n_i = 1'b0;
        cyc(5);
        chk("oe in reset", 8'h00, {4'h0, oe});
        g_oe  = 4'h0;
        g_out = 4'h0;
        g_ev  = 4'h0;
        rst_n_i = 1'b1;
        cyc(4);
        chk("oe", 8'h00, {4'h0, oe});
        chk("fm", 8'h00, {7'h0, fm});
        chk("speed", 8'h00, {5'h0, spd_q});
        chk("run", 8'h01, {7'h0, run});
        $display("test reset done");
    endtask
    // Upper pins follow general purpose settings without fan mode
    task automatic t_gpio();
        g_oe  = 4'h5;
        g_out = 4'h4;
        g_ev  = 4'hF;
        cyc(4);
        chk("oe", 8'h05, {4'h0, oe});
        chk("pin", 8'h04, {4'h0, pin});
        chk("stat", 8'h0F, {4'h0, stat});
        $display("test gpio done");
    endtask
    // Level zero in fan mode stops the fan
    task automatic t_off();
        wr(1'b1, 3'h0);
        cyc(3);
        chk("oe", 8'h08, {4'h0, oe});
        chk("pin", 8'h00, {4'h0, pin});
        chk("run", 8'h00, {7'h0, run});
        chk("stat", 8'h00, {4'h0, stat});
        chk("fm", 8'h01, {7'h0, fm});
        $display("test fan off done");
    endtask
    // Every nonzero level: restart from off, full-speed kick, then the level
    task automatic t_levels();
        for (int l = 1; l < 8; l++) begin
            wr(1'b1, 3'h0);
            cyc(3);
            wr(1'b1, l[2:0]);
            cyc(4);
            chk("kick fb", 8'h07, {5'h0, fb});
            cyc(KICK - 1);
            chk("kick end fb", 8'h07, {5'h0, fb});
            cyc(1);
            chk("fb", 8'(l), {5'h0, fb});
            chk("run", 8'h01, {7'h0, run});
            chk("speed", 8'(l), {5'h0, spd_q});
        end
        wr(1'b0, 3'h3);
        cyc(3);
        chk("oe", 8'h05, {4'h0, oe});
        $display("test levels done");
    endtask
    // Low clock enable freezes a kick in progress and ignores writes
    task automatic t_freeze();
        wr(1'b1, 3'h0);
        cyc(3);
        wr(1'b1, 3'h5);
        cyc(4);
        ce = 1'b0;
        wr(1'b1, 3'h2);
        cyc(KICK);
        chk("frozen fb", 8'h07, {5'h0, fb});
        chk("frozen speed", 8'h05, {5'h0, spd_q});
        ce = 1'b1;
        cyc(KICK - 1);
        chk("resumed kick fb", 8'h07, {5'h0, fb});
        cyc(1);
        chk("resumed fb", 8'h05, {5'h0, fb});
        chk("resumed speed", 8'h05, {5'h0, spd_q});
        wr(1'b0, 3'h0);
        cyc(3);
        $display("test freeze done");
    endtask
    // Print counts and verdict, end the run
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        t_reset();
        t_gpio();
        t_off();
        t_levels();
        t_freeze();
        t_reset();
        print_verdict();
    end
    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge clk_sys_i);
        num_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
